// ===== rtl/sdca_params.svh
// Timing counts, switch field positions and register offsets of the stepper drive block.
// Assumes a 125 MHz system clock and a classic Wishbone bus with 32-bit data.
`ifndef SDCA_PARAMS_SVH
`define SDCA_PARAMS_SVH
`define SDCA_CLK_MHZ        125
`define SDCA_BLINK_MS       250
`define SDCA_BLINK_CYC      (`SDCA_BLINK_MS * `SDCA_CLK_MHZ * 1000)
`define SDCA_IDLE_MS        500
`define SDCA_IDLE_CYC       (`SDCA_IDLE_MS * `SDCA_CLK_MHZ * 1000)
`define SDCA_TEST_US        1000
`define SDCA_TEST_CYC       (`SDCA_TEST_US * `SDCA_CLK_MHZ)
`define SDCA_FILT_US        2000
`define SDCA_FILT_CYC       (`SDCA_FILT_US * `SDCA_CLK_MHZ)
`define SDCA_TEST_STEPS     16'd400
`define SDCA_ADR_STATUS     8'h00
`define SDCA_ADR_IRQ_STAT   8'h04
`define SDCA_ADR_IRQ_MASK   8'h08
`define SDCA_ADR_POSITION   8'h0c
`define SDCA_ADR_SETTING    8'h10
`define SDCA_SW_SCALE_A     0
`define SDCA_SW_SCALE_B     1
`define SDCA_SW_INERTIA     2
`define SDCA_SW_IDLE        3
`define SDCA_SW_MODE_LO     4
`define SDCA_SW_TEST        7
`endif

// ===== rtl/sdca_pkg.sv
// Types shared by the stepper drive configuration and alarm block.
// Assumes the parameter header is compiled alongside.
package sdca_pkg;
  // Alarm sources; electrical ones in priority order, config lowest of all
  typedef enum logic [2:0] {
    SDCA_ALM_NONE, SDCA_ALM_CONFIG, SDCA_ALM_OVERVOLT, SDCA_ALM_OVERCUR,
    SDCA_ALM_OPEN, SDCA_ALM_INTVOLT, SDCA_ALM_UNDERVOLT
  } sdca_alarm_type;
  // Blink sequencer phases
  typedef enum logic [1:0] {SDCA_BL_GREEN, SDCA_BL_RED, SDCA_BL_GAP} sdca_blink_type;
endpackage : sdca_pkg

// ===== rtl/sdca_counter.sv
// Free-running terminal-count timer used for blink, idle, test and filter timing.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sdca_counter #(
  parameter int LIMIT = 16
) (
  input  wire logic CLK,
  input  wire logic SRST,
  input  wire logic restart,
  output logic      tick
);
  logic [31:0] count; // Cycles since last tick
  wire         at_end = (count == 32'(LIMIT - 1));
  // Count up, tick for one cycle at the limit
  always_ff @(posedge CLK) begin
    if (SRST || restart || at_end) count <= 32'h0;
    else                          count <= count + 32'h1;
  end
  assign tick = at_end && !restart && !SRST;
endmodule : sdca_counter
`default_nettype wire

// ===== rtl/sdca_drive.sv
// Stepper drive configuration, motion position and alarm blink logic.
// Assumes step/direction/enable synchronous to CLK, alarm levels from analogue monitors.
// Overview of operation
// - Rotary switch selects profile and current
// - Two switches scale current; both on: 70%
// - Switch three picks inertia range, damping follows
// - Idle current drops to 50 or 90 percent
// - Three switches choose six step resolutions
// - Finest resolution is 1/1000 full step
// - Smooth 200/400 modes filter coarse steps
// - Self-test rising edge runs 400-step oscillation
// - Green steady disabled, flashing enabled; red config
// - Alarms blink green then red counts
// - Blink pattern repeats until alarm clears
// - Step, direction, enable in; fault out
// - Electrical problem drives fault output
//
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sdca_params.svh"
module sdca_drive
  import sdca_pkg::*;
#(
  parameter int BLINK_CYC = `SDCA_BLINK_CYC,
  parameter int IDLE_CYC  = `SDCA_IDLE_CYC,
  parameter int TEST_CYC  = `SDCA_TEST_CYC,
  parameter int FILT_CYC  = `SDCA_FILT_CYC
) (
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic        STEP,
  input  wire logic        DIR,
  input  wire logic        ENABLE,
  output logic             FAULT,
  input  wire logic [3:0]  MOTOR_SELECT,
  input  wire logic [7:0]  CONFIG_SWITCH,
  input  wire logic        ALM_OVERVOLT,
  input  wire logic        ALM_OVERCUR,
  input  wire logic        ALM_OPEN,
  input  wire logic        ALM_INTVOLT,
  input  wire logic        ALM_UNDERVOLT,
  input  wire logic        ALM_MEMORY,
  output logic             LED_GREEN,
  output logic             LED_RED,
  output logic [7:0]       CURRENT_DECIAMP,
  output logic             INERTIA_HIGH,
  output logic             MOTION_ACTIVE,
  output logic [31:0]      POSITION,
  output logic             IRQ,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O
);
  // Rated current per rotary position in tenths of an amp
  function automatic logic [7:0] rated_current(input logic [3:0] sel);
    case (sel)
      4'h0, 4'h1: rated_current = 8'd14;
      4'h2, 4'hd: rated_current = 8'd36;
      4'h3, 4'h5: rated_current = 8'd43;
      4'h4:       rated_current = 8'd22;
      4'h6:       rated_current = 8'd47;
      4'h7:       rated_current = 8'd16;
      4'h8:       rated_current = 8'd20;
      4'h9, 4'ha: rated_current = 8'd24;
      4'hb:       rated_current = 8'd60;
      4'hc, 4'he: rated_current = 8'd72;
      default:    rated_current = 8'd78;
    endcase
  endfunction : rated_current

  // Switch decode
  wire       sw_a     = CONFIG_SWITCH[`SDCA_SW_SCALE_A];
  wire       sw_b     = CONFIG_SWITCH[`SDCA_SW_SCALE_B];
  wire       sw_idle  = CONFIG_SWITCH[`SDCA_SW_IDLE];
  wire [2:0] sw_mode  = CONFIG_SWITCH[`SDCA_SW_MODE_LO +: 3];
  wire       sw_test  = CONFIG_SWITCH[`SDCA_SW_TEST];
  wire [7:0] rated    = rated_current(MOTOR_SELECT);
  // Scale percent: both on 70, one on 80 or 90, off 100
  wire [6:0] scale_pct = (sw_a && sw_b) ? 7'd70 : sw_a ? 7'd80 : sw_b ? 7'd90 : 7'd100;
  // Microsteps per full step for six settings; codes 6 and 7 read as invalid
  wire [9:0] micro_per_step;
  wire       mode_smooth = (sw_mode == 3'd0) || (sw_mode == 3'd2);
  wire       mode_bad    = (sw_mode > 3'd5);
  assign micro_per_step = (sw_mode == 3'd0 || sw_mode == 3'd1) ? 10'd1 :
                          (sw_mode == 3'd2 || sw_mode == 3'd3) ? 10'd2 :
                          (sw_mode == 3'd4) ? 10'd10 :
                          (sw_mode == 3'd5) ? 10'd1000 : 10'd1;

  // Self-test edge and activity
  logic       test_prev;      // Previous self-test switch level
  logic       test_run;       // Oscillation in progress
  logic       test_dir;       // Current oscillation direction
  logic [15:0] test_count;    // Steps done in this direction
  logic       test_tick;      // Internal step rate
  wire        test_rise = sw_test && !test_prev;
  sdca_counter #(.LIMIT(TEST_CYC)) u_test_rate (
    .CLK(CLK), .SRST(SRST), .restart(test_rise), .tick(test_tick));
  // Self-test sequencer: stops when the switch goes off
  always_ff @(posedge CLK) begin
    test_prev <= sw_test; // Tracks the switch in reset too, so no false start after it
    if (SRST || !sw_test) begin
      test_run   <= 1'b0;
      test_dir   <= 1'b0;
      test_count <= 16'h0;
    end else if (test_rise) begin
      test_run   <= 1'b1;
      test_count <= 16'h0;
    end else if (test_run && test_tick) begin
      if (test_count == `SDCA_TEST_STEPS - 16'd1) begin
        test_count <= 16'h0;
        test_dir   <= !test_dir;
      end else begin
        test_count <= test_count + 16'h1;
      end
    end
  end

  // External step edge detect; external steps gated by enable and fault, self-test steps by fault only
  logic step_prev; // Previous step level
  wire  ext_step  = STEP && !step_prev && ENABLE && !FAULT;
  wire  int_step  = test_run && test_tick && !FAULT;
  wire  any_step  = test_run ? int_step : ext_step;
  wire  step_dir  = test_run ? test_dir : DIR;
  // Increment per accepted command in thousandths of a full step
  wire [31:0] step_inc = 32'(10'd1000 / micro_per_step);
  logic [31:0] position; // Commanded position in 1/1000 steps
  // Position accumulator
  always_ff @(posedge CLK) begin
    step_prev <= SRST ? 1'b0 : STEP;
    if (SRST)          position <= 32'h0;
    else if (any_step) position <= step_dir ? position - step_inc : position + step_inc;
  end

  // Smoothing filter: output position slews toward target over the filter window
  logic [31:0] smooth_pos; // Filtered position
  logic        filt_tick;  // Slew step cadence
  sdca_counter #(.LIMIT(FILT_CYC / 1000)) u_filt_rate (
    .CLK(CLK), .SRST(SRST), .restart(1'b0), .tick(filt_tick));
  always_ff @(posedge CLK) begin
    if (SRST)                            smooth_pos <= 32'h0;
    else if (!mode_smooth)               smooth_pos <= position;
    else if (filt_tick && smooth_pos != position) begin
      smooth_pos <= ($signed(position - smooth_pos) > 0) ? smooth_pos + 32'h1
                                                         : smooth_pos - 32'h1;
    end
  end
  assign POSITION = smooth_pos;

  // Idle detection: motion resets timer
  logic idle_tick; // Idle timeout reached
  logic idle;      // Motor standing still
  sdca_counter #(.LIMIT(IDLE_CYC)) u_idle (
    .CLK(CLK), .SRST(SRST), .restart(any_step), .tick(idle_tick));
  always_ff @(posedge CLK) begin
    if (SRST || any_step) idle <= 1'b0;
    else if (idle_tick)   idle <= 1'b1;
  end
  assign MOTION_ACTIVE = !idle;

  // Applied current: rated * scale * idle factor, in tenths of an amp
  wire [6:0]  idle_pct = !idle ? 7'd100 : (sw_idle ? 7'd90 : 7'd50);
  wire [20:0] cur_full = 21'(rated) * 21'(scale_pct) * 21'(idle_pct);
  logic [7:0] current; // Registered current setpoint
  always_ff @(posedge CLK) begin
    if (SRST) current <= 8'h0;
    else      current <= 8'(cur_full / 21'd10000);
  end
  assign CURRENT_DECIAMP = current;
  logic inertia; // Registered inertia range select
  // Inertia range follows switch three one cycle later
  always_ff @(posedge CLK) begin
    inertia <= CONFIG_SWITCH[`SDCA_SW_INERTIA];
  end
  assign INERTIA_HIGH    = inertia;

  // Alarm priority selection
  sdca_alarm_type alarm;
  wire cfg_err = ALM_MEMORY || mode_bad;
  assign alarm = ALM_OVERVOLT  ? SDCA_ALM_OVERVOLT :
                 ALM_OVERCUR   ? SDCA_ALM_OVERCUR :
                 ALM_OPEN      ? SDCA_ALM_OPEN :
                 ALM_INTVOLT   ? SDCA_ALM_INTVOLT :
                 ALM_UNDERVOLT ? SDCA_ALM_UNDERVOLT :
                 cfg_err       ? SDCA_ALM_CONFIG : SDCA_ALM_NONE;
  wire electrical = (alarm != SDCA_ALM_NONE) && (alarm != SDCA_ALM_CONFIG);
  // Blink counts per alarm
  wire [2:0] green_n = (alarm == SDCA_ALM_INTVOLT || alarm == SDCA_ALM_UNDERVOLT) ? 3'd2 : 3'd1;
  wire [2:0] red_n   = (alarm == SDCA_ALM_OVERVOLT)  ? 3'd4 :
                       (alarm == SDCA_ALM_OVERCUR)   ? 3'd5 :
                       (alarm == SDCA_ALM_OPEN)      ? 3'd6 :
                       (alarm == SDCA_ALM_INTVOLT)   ? 3'd3 : 3'd4;

  // Fault output follows electrical alarms
  always_ff @(posedge CLK) begin
    if (SRST) FAULT <= 1'b0;
    else      FAULT <= electrical;
  end

  // Blink sequencer: half period on, half off per flash
  logic           half_tick; // Blink half-period tick
  sdca_counter #(.LIMIT(BLINK_CYC)) u_blink (
    .CLK(CLK), .SRST(SRST), .restart(1'b0), .tick(half_tick));
  sdca_blink_type phase;     // Green, red or gap phase
  logic [3:0]     halves;    // Half periods in phase
  logic           lamp;      // Flash on half
  always_ff @(posedge CLK) begin
    if (SRST || !electrical) begin
      phase  <= SDCA_BL_GREEN;
      halves <= 4'h0;
    end else if (half_tick) begin
      case (phase)
        SDCA_BL_GREEN: begin
          if (halves == {green_n, 1'b1}) begin phase <= SDCA_BL_RED; halves <= 4'h0; end
          else halves <= halves + 4'h1;
        end
        SDCA_BL_RED: begin
          if (halves == {red_n[2:0], 1'b1} - 4'h0) begin phase <= SDCA_BL_GAP; halves <= 4'h0; end
          else halves <= halves + 4'h1;
        end
        SDCA_BL_GAP: begin
          if (halves == 4'h3) begin phase <= SDCA_BL_GREEN; halves <= 4'h0; end
          else halves <= halves + 4'h1;
        end
        default: phase <= SDCA_BL_GREEN;
      endcase
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST)           lamp <= 1'b0;
    else if (half_tick) lamp <= !lamp;
  end
  wire pulse_on = !halves[0] && (halves[3:1] != 3'd0 || 1'b1);

  // LED drivers
  logic led_g; // Green LED register
  logic led_r; // Red LED register
  always_ff @(posedge CLK) begin
    if (SRST) begin
      led_g <= 1'b0;
      led_r <= 1'b0;
    end else if (electrical) begin
      led_g <= (phase == SDCA_BL_GREEN) && pulse_on && (halves[3:1] < green_n);
      led_r <= (phase == SDCA_BL_RED) && pulse_on && (halves[3:1] < red_n);
    end else if (cfg_err) begin
      led_g <= 1'b0;
      led_r <= lamp;
    end else begin
      led_g <= ENABLE ? lamp : 1'b1;
      led_r <= 1'b0;
    end
  end
  assign LED_GREEN = led_g;
  assign LED_RED   = led_r;

  // Interrupt status: bit0 fault rise, bit1 config error rise, bit2 self-test start
  logic [2:0] irq_stat;  // Sticky events
  logic [2:0] irq_mask;  // Enables
  logic       fault_prev; // Previous fault
  logic       cfg_prev;   // Previous config error
  wire  [2:0] ev = {test_rise, cfg_err && !cfg_prev, electrical && !fault_prev};
  wire        wb_req   = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  // Writes land at the edge where the master sees ack high
  wire        wr       = WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I && WB_SEL_I[0];
  wire        wr_stat  = wr && (WB_ADR_I == `SDCA_ADR_IRQ_STAT);
  wire        wr_mask  = wr && (WB_ADR_I == `SDCA_ADR_IRQ_MASK);
  wire  [2:0] clr      = wr_stat ? WB_DAT_I[2:0] : 3'h0;
  // Set wins over write-one-to-clear
  always_ff @(posedge CLK) begin
    fault_prev <= SRST ? 1'b0 : electrical;
    cfg_prev   <= SRST ? 1'b0 : cfg_err;
    if (SRST) begin
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
    end else begin
      irq_stat <= (irq_stat & ~clr) | ev;
      if (wr_mask) irq_mask <= WB_DAT_I[2:0];
    end
  end
  assign IRQ = |(irq_stat & irq_mask);

  // Wishbone read decode, one ack cycle, registered one clock after the request
  wire [31:0] rd_status  = {16'h0, 1'b0, alarm, idle, test_run, FAULT, ENABLE,
                            current};
  wire [31:0] rd_setting = {20'h0, MOTOR_SELECT, CONFIG_SWITCH};
  wire [31:0] rd_mux =
    (WB_ADR_I == `SDCA_ADR_STATUS)   ? rd_status :
    (WB_ADR_I == `SDCA_ADR_IRQ_STAT) ? {29'h0, irq_stat} :
    (WB_ADR_I == `SDCA_ADR_IRQ_MASK) ? {29'h0, irq_mask} :
    (WB_ADR_I == `SDCA_ADR_POSITION) ? smooth_pos :
    (WB_ADR_I == `SDCA_ADR_SETTING)  ? rd_setting : 32'h0;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
    end else begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= wb_req ? rd_mux : 32'h0;
    end
  end
endmodule : sdca_drive
`default_nettype wire

// ===== test/sdca_drive_asserts.sv
// Port checker for the stepper drive block.
// Assumes one clock CLK and synchronous active-high reset SRST.
`timescale 1ns/1ps
`default_nettype none
module sdca_drive_asserts (
  input wire logic        CLK,
  input wire logic        SRST,
  input wire logic        STEP,
  input wire logic        DIR,
  input wire logic        ENABLE,
  input wire logic        FAULT,
  input wire logic [7:0]  CONFIG_SWITCH,
  input wire logic        ALM_OVERVOLT,
  input wire logic        ALM_OVERCUR,
  input wire logic        ALM_OPEN,
  input wire logic        ALM_INTVOLT,
  input wire logic        ALM_UNDERVOLT,
  input wire logic        INERTIA_HIGH,
  input wire logic [31:0] POSITION,
  input wire logic        IRQ,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  logic        elec;      // Any electrical alarm
  logic        prev_step; // Step level one edge back
  logic        edge_on;   // Step edge in full-step mode, enabled
  logic        edge_off;  // Same edge before the enable and fault gating
  logic [31:0] exp_pos;   // Position expected after the edge
  assign elec = ALM_OVERVOLT | ALM_OVERCUR | ALM_OPEN | ALM_INTVOLT | ALM_UNDERVOLT;
  assign edge_off = STEP & ~prev_step & ~CONFIG_SWITCH[7] & (CONFIG_SWITCH[6:4] == 3'h1);
  assign edge_on = edge_off & ENABLE & ~FAULT;
  // Tracks the step level and the target of each accepted step
  always_ff @(posedge CLK) begin
    prev_step <= STEP;
    if (edge_on) begin
      exp_pos <= POSITION + (DIR ? 32'hfffffc18 : 32'h3e8);
    end
  end
  ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request not answered");
  ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  unmapped_zero_a: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h20 |-> WB_DAT_O == 32'h0)
    else $error("unmapped read not zero");
  fault_set_a: assert property (elec |=> FAULT)
    else $error("fault not raised");
  fault_clear_a: assert property (!elec |=> !FAULT)
    else $error("fault without alarm");
  inertia_pin_a: assert property (INERTIA_HIGH == $past(CONFIG_SWITCH[2]))
    else $error("inertia range wrong");
  step_move_a: assert property (edge_on |=> ##[0:1] POSITION == exp_pos)
    else $error("step did not move position");
  step_hold_a: assert property (edge_off && !ENABLE |=> $stable(POSITION) [*3])
    else $error("disabled step moved position");
  reset_quiet_a: assert property ($fell(SRST) |-> !FAULT && !IRQ && !WB_ACK_O)
    else $error("outputs busy after reset");
endmodule : sdca_drive_asserts
bind sdca_drive sdca_drive_asserts chk (.CLK(CLK), .SRST(SRST), .STEP(STEP), .DIR(DIR),
  .ENABLE(ENABLE), .FAULT(FAULT), .CONFIG_SWITCH(CONFIG_SWITCH), .ALM_OVERVOLT(ALM_OVERVOLT),
  .ALM_OVERCUR(ALM_OVERCUR), .ALM_OPEN(ALM_OPEN), .ALM_INTVOLT(ALM_INTVOLT),
  .ALM_UNDERVOLT(ALM_UNDERVOLT), .INERTIA_HIGH(INERTIA_HIGH), .POSITION(POSITION), .IRQ(IRQ),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O));
`default_nettype wire

// ===== test/sdca_pulse_gen.sv
// Model of the step and direction pulse generator facing the drive.
// Assumes the bench calls its tasks; one axis only.
`timescale 1ns/1ps
`default_nettype none
module sdca_pulse_gen #(
  parameter int GAP = 1250
) (
  input  wire logic CLK,
  output logic      STEP,
  output logic      DIR,
  output logic      ENABLE
);
  initial begin
    STEP = 1'b0;
    DIR = 1'b0;
    ENABLE = 1'b0;
  end
  // Enable level toward the drive
  task automatic set_en(input logic en);
    @(posedge CLK);
    ENABLE <= en;
  endtask : set_en
  // One pulse with direction set up first, then the rate-limit gap
  task automatic send(input logic d);
    @(posedge CLK);
    DIR <= d;
    repeat (2) @(posedge CLK);
    STEP <= 1'b1;
    repeat (4) @(posedge CLK);
    STEP <= 1'b0;
    repeat (GAP) @(posedge CLK);
  endtask : send
endmodule : sdca_pulse_gen
`default_nettype wire

// ===== test/stepper_drive_config_and_alarm_bench.sv
// Self-checking bench for the stepper drive block.
// Assumes shortened timing parameters and the pulse generator model.
`timescale 1ns/1ps
`default_nettype none
module stepper_drive_config_and_alarm_bench;
  import sdca_pkg::*;
  logic CLK = 1'b0, SRST = 1'b1, STEP, DIR, ENABLE, FAULT, LED_GREEN, LED_RED;
  logic ALM_OVERVOLT = 0, ALM_OVERCUR = 0, ALM_OPEN = 0, ALM_INTVOLT = 0, ALM_UNDERVOLT = 0;
  logic ALM_MEMORY = 0, INERTIA_HIGH, MOTION_ACTIVE, IRQ, WB_ACK_O;
  logic WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0;
  logic [3:0]  MOTOR_SELECT = 4'h0, WB_SEL_I = 4'h0;
  logic [7:0]  CONFIG_SWITCH = 8'h10, CURRENT_DECIAMP, WB_ADR_I = 8'h0;
  logic [31:0] POSITION, WB_DAT_I = 32'h0, WB_DAT_O, q, p;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  sdca_drive #(.BLINK_CYC(8), .IDLE_CYC(16), .TEST_CYC(4), .FILT_CYC(4000)) dut (
    .CLK(CLK), .SRST(SRST), .STEP(STEP), .DIR(DIR), .ENABLE(ENABLE), .FAULT(FAULT),
    .MOTOR_SELECT(MOTOR_SELECT), .CONFIG_SWITCH(CONFIG_SWITCH), .ALM_OVERVOLT(ALM_OVERVOLT),
    .ALM_OVERCUR(ALM_OVERCUR), .ALM_OPEN(ALM_OPEN), .ALM_INTVOLT(ALM_INTVOLT),
    .ALM_UNDERVOLT(ALM_UNDERVOLT), .ALM_MEMORY(ALM_MEMORY), .LED_GREEN(LED_GREEN),
    .LED_RED(LED_RED), .CURRENT_DECIAMP(CURRENT_DECIAMP), .INERTIA_HIGH(INERTIA_HIGH),
    .MOTION_ACTIVE(MOTION_ACTIVE), .POSITION(POSITION), .IRQ(IRQ), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O));
  sdca_pulse_gen gen (.CLK(CLK), .STEP(STEP), .DIR(DIR), .ENABLE(ENABLE));
  always #4 CLK = ~CLK;
  // Cuts a hang short
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One classic bus cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    WB_SEL_I <= 4'hf;
    do @(posedge CLK); while (WB_ACK_O !== 1'b1);
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
  endtask : wb
  // Switch readback, idle current and read-only places
  task automatic test_switches;
    logic [19:0] t[3] = '{20'hf1027, 20'h81707, 20'h01007};
    foreach (t[i]) begin
      MOTOR_SELECT <= t[i][19:16];
      CONFIG_SWITCH <= t[i][15:8];
      repeat (40) @(posedge CLK);
      wb(1'b1, 8'h10, 32'h0);
      wb(1'b0, 8'h10, 32'h0);
      chk(q, {20'h0, t[i][19:8]});
      chk(CURRENT_DECIAMP, t[i][7:0]);
      chk(INERTIA_HIGH, t[i][10]);
      chk(MOTION_ACTIVE, 1'b0);
      chk(LED_GREEN, 1'b1);
    end
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    $display("switch test done");
  endtask : test_switches
  // Step size per mode, direction, and disable
  task automatic test_steps;
    logic [34:0] t[4] = '{{3'h1, 32'd1000}, {3'h3, 32'd500}, {3'h4, 32'd100}, {3'h5, 32'd1}};
    gen.set_en(1'b1);
    repeat (2) @(posedge CLK);
    p = LED_GREEN;
    repeat (8) @(posedge CLK);
    chk(LED_GREEN, !p[0]);
    foreach (t[i]) begin
      CONFIG_SWITCH <= {1'b0, t[i][34:32], 4'h0};
      p = POSITION;
      gen.send(1'b0);
      chk(POSITION, p + t[i][31:0]);
      gen.send(1'b1);
      chk(POSITION, p);
    end
    CONFIG_SWITCH <= 8'h00; // Single axis, so every axis shares this smoothing
    gen.send(1'b0);
    tests_run++;
    if (POSITION === p || POSITION === p + 32'd1000) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, POSITION, p + 32'd500);
    end
    repeat (4000) @(posedge CLK);
    chk(POSITION, p + 32'd1000);
    CONFIG_SWITCH <= 8'h10;
    gen.set_en(1'b0);
    gen.send(1'b0);
    chk(POSITION, p + 32'd1000);
    $display("step test done");
  endtask : test_steps
  // Blink counts, fault line and interrupt per alarm, then configuration errors
  task automatic test_alarms;
    logic pg, pr;
    int reds, greens;
    wb(1'b1, 8'h08, 32'h3);
    for (int a = 0; a < 5; a++) begin
      {ALM_UNDERVOLT, ALM_INTVOLT, ALM_OPEN, ALM_OVERCUR, ALM_OVERVOLT} <= 5'h1 << a;
      repeat (2) begin
        reds = 0;
        greens = 0;
        do begin
          pg = LED_GREEN;
          pr = LED_RED;
          @(posedge CLK);
          if (LED_RED && !pr) reds++;
          if (LED_GREEN && !pg) greens++;
        end while (!(LED_GREEN && !pg && reds > 0));
      end
      chk(greens, (a < 3) ? 1 : 2);
      chk(reds, (a < 3) ? 4 + a : a);
      chk(FAULT, 1'b1);
      chk(IRQ, 1'b1);
      wb(1'b0, 8'h04, 32'h0);
      chk(q, 32'h1);
      wb(1'b1, 8'h04, 32'h1);
      @(posedge CLK);
      chk(IRQ, 1'b0);
      {ALM_UNDERVOLT, ALM_INTVOLT, ALM_OPEN, ALM_OVERCUR, ALM_OVERVOLT} <= 5'h0;
      repeat (3) @(posedge CLK);
      chk(FAULT, 1'b0);
    end
    // Memory error, then an invalid step mode: red flashes, no fault
    for (int k = 0; k < 2; k++) begin
      if (k == 0) ALM_MEMORY <= 1'b1;
      else CONFIG_SWITCH <= 8'h60;
      repeat (3) @(posedge CLK);
      pr = LED_RED;
      chk(LED_GREEN, 1'b0);
      chk(FAULT, 1'b0);
      chk(IRQ, 1'b1);
      repeat (8) @(posedge CLK);
      chk(LED_RED, !pr);
      wb(1'b0, 8'h04, 32'h0);
      chk(q, 32'h2);
      wb(1'b1, 8'h04, 32'h2);
      @(posedge CLK);
      chk(IRQ, 1'b0);
      ALM_MEMORY <= 1'b0;
      CONFIG_SWITCH <= 8'h10;
      repeat (3) @(posedge CLK);
    end
    $display("alarm test done");
  endtask : test_alarms
  // Self-test swings 400 full steps each way
  task automatic test_self;
    logic signed [31:0] lo, hi;
    lo = POSITION;
    hi = POSITION;
    CONFIG_SWITCH <= 8'h90;
    repeat (4000) begin
      @(posedge CLK);
      if ($signed(POSITION) < lo) lo = POSITION;
      if ($signed(POSITION) > hi) hi = POSITION;
    end
    chk(hi - lo, 32'd400000);
    CONFIG_SWITCH <= 8'h10;
    wb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h4);
    $display("self-test done");
  endtask : test_self
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  initial begin
    repeat (16) @(posedge CLK);
    SRST <= 1'b0;
    test_switches();
    test_steps();
    test_alarms();
    test_self();
    complete_run();
  end
endmodule : stepper_drive_config_and_alarm_bench
`default_nettype wire
